// ===== sim/ppc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output var  logic [7:0] pin_in
);
  // A driven pin shows the device level, an undriven one the outside level
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  end
endmodule : ppc_pin_model

`default_nettype wire

// ===== sim/test_port_pin_control_and_data.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module test_port_pin_control_and_data;
  import ppc_pkg::*;
  logic               clk, rst_b, wr, rd;
  logic [2:0]         addr;
  logic [7:0]         wdata, rdata, fdir, pin_in, pin_out, pin_oe, ext, rv;
  logic [7:0]         pu, sl, dr, fl, lat, dir;
  ppc_first_ctrl_type fctrl;
  int                 err_count, cmp_count, cycles;

  always #5 clk = ~clk;

  ppc_top i_ppc_top (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FIRST_PORT_DIR(fdir), .FIRST_CTRL(fctrl),
    .SECOND_PIN_IN(pin_in), .SECOND_PIN_OUT(pin_out), .SECOND_PIN_OE(pin_oe));
  ppc_pin_model i_ppc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
    .pin_in(pin_in));

  function automatic logic [7:0] exp_read(logic [7:0] l, logic [7:0] d, logic [7:0] p);
    logic [7:0] oe;
    oe = d | `PPC_OUT_ONLY_MASK;
    return (oe & l) | (~oe & p);
  endfunction : exp_read

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg

  // Write and read back the same register with no gap between the strobes
  task automatic wr_rd(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : wr_rd

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Cut a hang short well beyond the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic reset_and_check();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check(fctrl, 32'h000000FF);
    check({pin_oe & 8'hFE, pin_out}, 16'h0000);
    for (int a = 0; a < 8; a++) begin
      rd_reg(3'(a));
      check(rv, (a == 3) ? 8'hFF : ((a == 4) ? exp_read(8'h00, 8'h00, ext) : 8'h00));
    end
  endtask : reset_and_check

  initial begin
    clk = 1'b0;
    rst_b = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    fdir = 8'h00;
    ext = 8'h00;
    void'($urandom(32'h63D4D653));
    reset_and_check();
    for (int i = 0; i < 24; i++) begin
      pu  = (i < 2) ? 8'hFF : 8'($urandom);
      sl  = (i < 2) ? 8'hFF : 8'($urandom);
      dr  = (i < 2) ? 8'hFF : 8'($urandom);
      fl  = (i == 0) ? 8'h00 : 8'($urandom);
      dir = (i == 1 || i == 2) ? 8'h00 : 8'($urandom);
      lat = 8'($urandom);
      @(posedge clk);
      fdir <= (i == 1) ? 8'hFF : ((i == 0) ? 8'h00 : 8'($urandom));
      ext  <= (i == 1) ? 8'hFF : ((i == 2) ? 8'h00 : 8'($urandom));
      wr_rd(`PPC_OFS_PULLUP, pu);
      check(rv, pu);
      wr_rd(`PPC_OFS_SLEW, sl);
      check(rv, sl);
      wr_rd(`PPC_OFS_DRIVE, dr);
      check(rv, dr);
      wr_rd(`PPC_OFS_FILTER, fl);
      check(rv, fl);
      wr_rd(`PPC_OFS_DIR, dir);
      check(rv, dir);
      wr_rd(`PPC_OFS_DATA, lat);
      check(rv, exp_read(lat, dir, ext));
      wr_reg(3'h6 + 3'(i & 1), 8'($urandom));
      check(fctrl, {pu & ~fdir, sl & fdir, dr, fl});
      check({pin_oe, pin_out}, {dir | 8'h01, lat});
      rd_reg(`PPC_OFS_DATA);
      check(rv, exp_read(lat, dir, ext));
      rd_reg(`PPC_OFS_DIR);
      check(rv, dir);
      rd_reg(`PPC_OFS_FILTER);
      check(rv, fl);
    end
    reset_and_check();
    complete_run();
  end
endmodule : test_port_pin_control_and_data

`default_nettype wire

// ===== src/ppc_pkg.sv
package ppc_pkg;

  typedef logic [7:0] ppc_byte_type;

  // Pad controls of the first port, one bit per pin
  typedef struct packed {
    ppc_byte_type pullup_on;
    ppc_byte_type slew_on;
    ppc_byte_type drive_high;
    ppc_byte_type filter_on;
  } ppc_first_ctrl_type;

  typedef enum logic [2:0] {
    PPC_SEL_PULLUP,
    PPC_SEL_SLEW,
    PPC_SEL_DRIVE,
    PPC_SEL_FILTER,
    PPC_SEL_DATA,
    PPC_SEL_DIR,
    PPC_SEL_NONE
  } ppc_sel_type;

endpackage : ppc_pkg

// ===== src/ppc_regs.svh
// Behaviour
// - Pull-up bit 1 turns on first-port pin pull-up, 0 turns it off.
// - First-port pin driven as output keeps its pull-up off whatever the bit.
// - Slew bit 1 enables output slew limiting on its first-port pin, 0 disables.
// - Slew bit has no effect while its first-port pin is an input.
// - Drive bit selects low or high output drive of its first-port pin.
// - Filter bit 1 enables the input low-pass filter, 0 disables it.
// - Filter bits are set during and after reset.
// - Software writing 0 to a filter bit switches that filter off.
// - Second-port bit 0 is output only; input-related controls do nothing.
// - Data reads return the pin level for second-port pins that are inputs.
// - Every data write is stored into all eight latch bits.
// - Second-port output pins are driven with their latch bit.
// - Reset clears the latch; only the zero of bit 0 is driven out.
// - After reset port pins other than second-port bit 0 are undriven inputs with pull-ups off.
// - Direction 0 disables the driver; data reads return the pin level.
// - Direction 1 enables the driver; data reads return the latch.
// - Reads of latch bit 0 always return the latch value.
// - Direction bit 0 has no effect on the output-only pin.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_ADDR_W        3
`define PPC_DATA_W        8

`define PPC_OFS_PULLUP    3'h0
`define PPC_OFS_SLEW      3'h1
`define PPC_OFS_DRIVE     3'h2
`define PPC_OFS_FILTER    3'h3
`define PPC_OFS_DATA      3'h4
`define PPC_OFS_DIR       3'h5

`define PPC_RST_PULLUP    8'h00
`define PPC_RST_SLEW      8'h00
`define PPC_RST_DRIVE     8'h00
`define PPC_RST_FILTER    8'hFF
`define PPC_RST_DATA      8'h00
`define PPC_RST_DIR       8'h00

`define PPC_OUT_ONLY_MASK 8'h01
`define PPC_SYNC_STAGES   2

`endif

// ===== src/ppc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module ppc_top (
  input  wire logic                        CLK,
  input  wire logic                        RST_B,
  input  wire logic [`PPC_ADDR_W-1:0]      ADDR,
  input  wire logic [`PPC_DATA_W-1:0]      WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output var  logic [`PPC_DATA_W-1:0]      RDATA,
  input  wire logic [7:0]                  FIRST_PORT_DIR,
  output var  ppc_pkg::ppc_first_ctrl_type FIRST_CTRL,
  input  wire logic [7:0]                  SECOND_PIN_IN,
  output var  logic [7:0]                  SECOND_PIN_OUT,
  output var  logic [7:0]                  SECOND_PIN_OE
);
  import ppc_pkg::*;

  ppc_byte_type pullup_reg;
  ppc_byte_type slew_reg;
  ppc_byte_type drive_reg;
  ppc_byte_type filter_reg;
  ppc_byte_type data_reg;
  ppc_byte_type dir_reg;
  ppc_byte_type sync1_reg;
  ppc_byte_type sync2_reg;
  ppc_byte_type data_view;
  ppc_byte_type eff_dir;
  ppc_byte_type rdata_next;
  ppc_byte_type rdata_reg;
  ppc_sel_type  wr_sel;
  ppc_sel_type  rd_sel;

  function automatic ppc_sel_type ppc_decode(input logic [`PPC_ADDR_W-1:0] a);
    unique case (a)
      `PPC_OFS_PULLUP: ppc_decode = PPC_SEL_PULLUP;
      `PPC_OFS_SLEW:   ppc_decode = PPC_SEL_SLEW;
      `PPC_OFS_DRIVE:  ppc_decode = PPC_SEL_DRIVE;
      `PPC_OFS_FILTER: ppc_decode = PPC_SEL_FILTER;
      `PPC_OFS_DATA:   ppc_decode = PPC_SEL_DATA;
      `PPC_OFS_DIR:    ppc_decode = PPC_SEL_DIR;
      default:         ppc_decode = PPC_SEL_NONE;
    endcase
  endfunction : ppc_decode

  assign wr_sel = WR ? ppc_decode(ADDR) : PPC_SEL_NONE;
  assign rd_sel = RD ? ppc_decode(ADDR) : PPC_SEL_NONE;

  // First-port control registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pullup_reg <= `PPC_RST_PULLUP;
    end else if (wr_sel == PPC_SEL_PULLUP) begin
      pullup_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slew_reg <= `PPC_RST_SLEW;
    end else if (wr_sel == PPC_SEL_SLEW) begin
      slew_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      drive_reg <= `PPC_RST_DRIVE;
    end else if (wr_sel == PPC_SEL_DRIVE) begin
      drive_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      filter_reg <= `PPC_RST_FILTER;
    end else if (wr_sel == PPC_SEL_FILTER) begin
      filter_reg <= WDATA;
    end
  end

  // Second-port latch and direction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      data_reg <= `PPC_RST_DATA;
    end else if (wr_sel == PPC_SEL_DATA) begin
      data_reg <= WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_reg <= `PPC_RST_DIR;
    end else if (wr_sel == PPC_SEL_DIR) begin
      dir_reg <= WDATA;
    end
  end

  // Two-stage pin synchroniser; only the second stage is read
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= SECOND_PIN_IN;
      sync2_reg <= sync1_reg;
    end
  end

  // Output-only bit ignores its direction bit and is always driven
  assign eff_dir = dir_reg | `PPC_OUT_ONLY_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_view
      // Outputs read the latch, inputs read the synchronised pin
      assign data_view[gi] = eff_dir[gi] ? data_reg[gi] : sync2_reg[gi];
    end
  endgenerate

  always_comb begin
    rdata_next = 8'h00;
    unique case (rd_sel)
      PPC_SEL_PULLUP: rdata_next = pullup_reg;
      PPC_SEL_SLEW:   rdata_next = slew_reg;
      PPC_SEL_DRIVE:  rdata_next = drive_reg;
      PPC_SEL_FILTER: rdata_next = filter_reg;
      PPC_SEL_DATA:   rdata_next = data_view;
      PPC_SEL_DIR:    rdata_next = dir_reg;
      PPC_SEL_NONE:   rdata_next = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  // Pad control outputs
  assign FIRST_CTRL.pullup_on  = pullup_reg & ~FIRST_PORT_DIR;
  assign FIRST_CTRL.slew_on    = slew_reg & FIRST_PORT_DIR;
  assign FIRST_CTRL.drive_high = drive_reg;
  assign FIRST_CTRL.filter_on  = filter_reg;

  assign SECOND_PIN_OUT = data_reg;
  assign SECOND_PIN_OE  = eff_dir;

  // Checks
  AST_PULLUP_OUT_OFF: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (FIRST_CTRL.pullup_on & FIRST_PORT_DIR) == 8'h00)
    else $error("pull-up on for a pin driven as output");

  AST_PULLUP_FOLLOWS: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_PULLUP) |=>
      FIRST_CTRL.pullup_on == ($past(WDATA) & ~FIRST_PORT_DIR))
    else $error("pull-up outputs do not follow written value");

  AST_SLEW_INPUT_OFF: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (FIRST_CTRL.slew_on & ~FIRST_PORT_DIR) == 8'h00)
    else $error("slew limiting on for an input pin");

  AST_SLEW_FOLLOWS: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_SLEW) |=>
      FIRST_CTRL.slew_on == ($past(WDATA) & FIRST_PORT_DIR))
    else $error("slew outputs do not follow written value");

  AST_DRIVE_FOLLOWS: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DRIVE) |=> FIRST_CTRL.drive_high == $past(WDATA))
    else $error("drive select does not follow written value");

  AST_FILTER_CLEAR: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_FILTER) |=> FIRST_CTRL.filter_on == $past(WDATA))
    else $error("filter enable does not follow written value");

  AST_FILTER_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_FILTER) |=> $stable(FIRST_CTRL.filter_on))
    else $error("filter enable changed without a write");

  AST_LATCH_ALL: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DATA) |=> SECOND_PIN_OUT == $past(WDATA))
    else $error("data write not stored into all latch bits");

  AST_OE_DIR: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DIR) |=>
      SECOND_PIN_OE == ($past(WDATA) | `PPC_OUT_ONLY_MASK))
    else $error("driver enables do not follow direction write");

  AST_BIT0_DRIVEN: assert property (
    @(posedge CLK) disable iff (!RST_B)
    SECOND_PIN_OE[0])
    else $error("output-only pin not driven");

  AST_READ_DATA: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (RD && ADDR == `PPC_OFS_DATA && !WR) |=>
      (RDATA & $past(eff_dir)) == ($past(data_reg) & $past(eff_dir)))
    else $error("data read of output bits differs from latch");

  AST_READ_PIN: assert property (
    @(posedge CLK) disable iff (!RST_B)
    ((SECOND_PIN_IN | `PPC_OUT_ONLY_MASK) == 8'hFF)[*3] ##0
      (RD && ADDR == `PPC_OFS_DATA && dir_reg == 8'h00) |=> (RDATA | `PPC_OUT_ONLY_MASK) == 8'hFF)
    else $error("data read of input bits differs from pin");

  AST_READ_ONCE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !RD |=> RDATA == 8'h00)
    else $error("read data present without a read strobe");

  AST_DIR_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DIR) ##1 (RD && ADDR == `PPC_OFS_DIR) |=>
      RDATA == $past(WDATA, 2))
    else $error("direction readback wrong");

  // Reset values are checked while reset is held
  AST_RST_OUTPUTS: assert property (
    @(posedge CLK)
    !RST_B |-> (FIRST_CTRL.pullup_on == 8'h00 && SECOND_PIN_OE == `PPC_OUT_ONLY_MASK))
    else $error("pins not undriven inputs with pull-ups off during reset");

  AST_RST_FILTER: assert property (
    @(posedge CLK)
    !RST_B |-> FIRST_CTRL.filter_on == 8'hFF)
    else $error("filter enables not set during reset");

  AST_RST_LATCH: assert property (
    @(posedge CLK)
    !RST_B |-> SECOND_PIN_OUT == 8'h00)
    else $error("data latch not cleared during reset");

  AST_RST_RDATA: assert property (
    @(posedge CLK)
    !RST_B |-> RDATA == 8'h00)
    else $error("read data not cleared during reset");

  AST_PULLUP_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_PULLUP) ##1 $stable(FIRST_PORT_DIR) |-> $stable(FIRST_CTRL.pullup_on))
    else $error("pull-up outputs changed without a write");

  AST_SLEW_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_SLEW) ##1 $stable(FIRST_PORT_DIR) |-> $stable(FIRST_CTRL.slew_on))
    else $error("slew outputs changed without a write");

  AST_DRIVE_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_DRIVE) |=> $stable(FIRST_CTRL.drive_high))
    else $error("drive select changed without a write");

  AST_LATCH_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_DATA) |=> $stable(SECOND_PIN_OUT))
    else $error("data latch changed without a write");

  AST_DIR_HOLD: assert property (
    @(posedge CLK) disable iff (!RST_B)
    !(WR && ADDR == `PPC_OFS_DIR) |=> $stable(SECOND_PIN_OE))
    else $error("driver enables changed without a write");

  AST_READ_BIT0: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (RD && ADDR == `PPC_OFS_DATA) |=> RDATA[0] == $past(SECOND_PIN_OUT[0]))
    else $error("read of output-only bit differs from latch");

  AST_UNMAPPED_READ: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (RD && ADDR > `PPC_OFS_DIR) |=> RDATA == 8'h00)
    else $error("unmapped read returned nonzero data");

  AST_UNMAPPED_WRITE: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR > `PPC_OFS_DIR) |=>
      ($stable(SECOND_PIN_OUT) && $stable(SECOND_PIN_OE) && $stable(FIRST_CTRL.filter_on)))
    else $error("unmapped write changed a register");

  AST_READ_PIN_LOW: assert property (
    @(posedge CLK) disable iff (!RST_B)
    ((SECOND_PIN_IN & ~`PPC_OUT_ONLY_MASK) == 8'h00)[*3] ##0
      (RD && ADDR == `PPC_OFS_DATA && dir_reg == 8'h00) |=> (RDATA & ~`PPC_OUT_ONLY_MASK) == 8'h00)
    else $error("data read of low input bits differs from pin");

  // Pin levels reach the read path two edges after they are sampled
  AST_SYNC_DELAY: assert property (
    @(posedge CLK) disable iff (!RST_B)
    $past(RST_B, 2) |-> sync2_reg == $past(SECOND_PIN_IN, 2))
    else $error("pin synchroniser delay wrong");

  AST_DATA_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DATA) ##1 (RD && ADDR == `PPC_OFS_DATA) |=>
      (RDATA & $past(SECOND_PIN_OE)) == ($past(WDATA, 2) & $past(SECOND_PIN_OE)))
    else $error("data readback of output bits wrong");

  AST_PULLUP_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_PULLUP) ##1 (RD && ADDR == `PPC_OFS_PULLUP) |=>
      RDATA == $past(WDATA, 2))
    else $error("pull-up readback wrong");

  AST_SLEW_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_SLEW) ##1 (RD && ADDR == `PPC_OFS_SLEW) |=>
      RDATA == $past(WDATA, 2))
    else $error("slew readback wrong");

  AST_DRIVE_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DRIVE) ##1 (RD && ADDR == `PPC_OFS_DRIVE) |=>
      RDATA == $past(WDATA, 2))
    else $error("drive readback wrong");

  AST_FILTER_READBACK: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_FILTER) ##1 (RD && ADDR == `PPC_OFS_FILTER) |=>
      RDATA == $past(WDATA, 2))
    else $error("filter readback wrong");

  AST_FILTER_ZERO: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_FILTER && WDATA == 8'h00) |=> FIRST_CTRL.filter_on == 8'h00)
    else $error("filter still on after clearing write");

  AST_PULLUP_INPUT_ON: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_PULLUP && WDATA == 8'hFF) ##1 (FIRST_PORT_DIR == 8'h00)
      |-> FIRST_CTRL.pullup_on == 8'hFF)
    else $error("pull-up off on an input pin with its bit set");

  AST_SLEW_ALL_ON: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_SLEW && WDATA == 8'hFF) ##1 (FIRST_PORT_DIR == 8'hFF)
      |-> FIRST_CTRL.slew_on == 8'hFF)
    else $error("slew limiting off on an output pin with its bit set");

  AST_OE_INPUTS: assert property (
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == `PPC_OFS_DIR && WDATA == 8'h00) |=> SECOND_PIN_OE == `PPC_OUT_ONLY_MASK)
    else $error("driver enabled on a pin set as input");

endmodule : ppc_top

`default_nettype wire
